/* hw/opa_pkg.sv */
package opa_pkg;

  typedef enum logic [2:0] {
    MODE_SRC_IMM, MODE_SRC_DIR, MODE_SRC_IDX, MODE_DST_DIR,
    MODE_DST_IDX, MODE_DST_DIR_IMM, MODE_DST_IDX_IMM
  } opa_mode_e;

  typedef enum logic [2:0] {ALU_MOV, ALU_ADD, ALU_AND, ALU_OR, ALU_XOR} opa_alu_e;

  typedef enum logic [1:0] {TGT_A, TGT_X, TGT_SP, TGT_F} opa_tgt_e;

  // Register offsets on the software port.
  localparam logic [7:0] REG_INSTR   = 8'h00;
  localparam logic [7:0] REG_OPER    = 8'h04;
  localparam logic [7:0] REG_ACC     = 8'h08;
  localparam logic [7:0] REG_IDX     = 8'h0c;
  localparam logic [7:0] REG_SP      = 8'h10;
  localparam logic [7:0] REG_FLAGS   = 8'h14;
  localparam logic [7:0] REG_PC_LOW  = 8'h18;
  localparam logic [7:0] REG_PC_HIGH = 8'h1c;
  localparam logic [7:0] REG_STATUS  = 8'h20;

  // Field positions.
  localparam int INSTR_MODE_LSB  = 0;
  localparam int INSTR_ALU_LSB   = 3;
  localparam int INSTR_TGT_LSB   = 6;
  localparam int INSTR_SPACE_BIT = 8;
  localparam int OPER_OP1_LSB    = 0;
  localparam int OPER_OP2_LSB    = 8;
  localparam int FLAG_ZERO       = 1;
  localparam int FLAG_CARRY      = 2;
  localparam int FLAG_BANK       = 4;

  // Reset values and fixed figures.
  localparam logic [7:0]  ACC_RST        = 8'h00;
  localparam logic [7:0]  IDX_RST        = 8'h00;
  localparam logic [7:0]  SP_RST         = 8'h00;
  localparam logic [7:0]  FLAGS_RST      = 8'h02;
  localparam logic [7:0]  FLAGS_WR_MASK  = 8'h17;
  localparam logic [7:0]  PC_HIGH_RST    = 8'h00;
  localparam logic [7:0]  PC_LOW_RST     = 8'h00;
  localparam logic [15:0] LEN_SHORT      = 16'h0002;
  localparam logic [15:0] LEN_LONG       = 16'h0003;

endpackage : opa_pkg

/* hw/opa_alu_if.sv */
`timescale 1ns/1ps
interface opa_alu_if;
  opa_pkg::opa_alu_e  op;
  opa_pkg::opa_mode_e mode;
  logic [7:0]         oper1;
  logic [7:0]         x_val;
  logic [7:0]         a_in;
  logic [7:0]         b_in;
  logic [7:0]         result;
  logic [7:0]         addr;
  logic               carry;

  modport core (output op, mode, oper1, x_val, a_in, b_in, input result, carry, addr);
  modport unit (input op, mode, oper1, x_val, a_in, b_in, output result, carry, addr);
endinterface : opa_alu_if

/* hw/opa_alu_agen.sv */
`timescale 1ns/1ps
module opa_alu_agen (
  opa_alu_if.unit alu
);
  logic       indexed;
  logic [8:0] sum;

  always_comb begin
    indexed = (alu.mode == opa_pkg::MODE_SRC_IDX) || (alu.mode == opa_pkg::MODE_DST_IDX) ||
              (alu.mode == opa_pkg::MODE_DST_IDX_IMM);
    // The carry out of the index add is dropped so the address wraps.
    alu.addr = indexed ? 8'(alu.oper1 + alu.x_val) : alu.oper1;
    sum      = {1'b0, alu.a_in} + {1'b0, alu.b_in};
    alu.carry = 1'b0;
    case (alu.op)
      opa_pkg::ALU_MOV: alu.result = alu.b_in;
      opa_pkg::ALU_ADD: begin
        alu.result = sum[7:0];
        alu.carry  = sum[8];
      end
      opa_pkg::ALU_AND: alu.result = alu.a_in & alu.b_in;
      opa_pkg::ALU_OR:  alu.result = alu.a_in | alu.b_in;
      opa_pkg::ALU_XOR: alu.result = alu.a_in ^ alu.b_in;
      default:          alu.result = alu.b_in;
    endcase
  end
endmodule : opa_alu_agen

/* hw/opa_core.sv */
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
// How it works
// - PC high byte register, resets zero.
// - PC low byte register, resets zero.
// - Immediate source writes A, F, SP or X.
// - Direct source reads addressed location into A/X.
// - Indexed source address is operand plus X.
// - Direct destination writes addressed location.
// - Indexed destination sources A at operand plus X.
// - Direct destination immediate, three bytes long.
// - Indexed destination immediate, three bytes long.
// - Stores to memory leave A unchanged.
// - AND immediate into F updates flags.
// - Flag bit 4 selects register bank.
module opa_core (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  output logic      [7:0]  mem_addr,
  output logic             mem_reg_space,
  output logic             mem_bank,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata
);
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_EXEC} opa_st_e;

  typedef struct packed {
    opa_st_e            st;
    logic [7:0]         acc;
    logic [7:0]         idx;
    logic [7:0]         sp;
    logic [7:0]         flags;
    logic [7:0]         pc_high;
    logic [7:0]         pc_low;
    opa_pkg::opa_mode_e mode;
    opa_pkg::opa_alu_e  op;
    opa_pkg::opa_tgt_e  tgt;
    logic               space;
    logic [7:0]         op1;
    logic [7:0]         op2;
    logic [31:0]        rdata;
    logic [7:0]         maddr;
    logic               mspace;
    logic               mbank;
    logic               mrd;
    logic               mwr;
    logic [7:0]         mwdata;
  } opa_state_s;

  opa_state_s s_q;
  opa_state_s s_d;
  opa_alu_if  alu ();

  opa_alu_agen u_agen (
    .alu (alu.unit)
  );

  function automatic logic is_dst(input opa_pkg::opa_mode_e m);
    is_dst = (m == opa_pkg::MODE_DST_DIR) || (m == opa_pkg::MODE_DST_IDX) ||
             (m == opa_pkg::MODE_DST_DIR_IMM) || (m == opa_pkg::MODE_DST_IDX_IMM);
  endfunction : is_dst

  function automatic logic is_long(input opa_pkg::opa_mode_e m);
    is_long = (m == opa_pkg::MODE_DST_DIR_IMM) || (m == opa_pkg::MODE_DST_IDX_IMM);
  endfunction : is_long

  logic       needs_read;
  logic [7:0] tgt_val;
  logic [7:0] flags_new;
  logic [15:0] pc_next;

  always_comb begin
    case (s_q.tgt)
      opa_pkg::TGT_A:  tgt_val = s_q.acc;
      opa_pkg::TGT_X:  tgt_val = s_q.idx;
      opa_pkg::TGT_SP: tgt_val = s_q.sp;
      default:         tgt_val = s_q.flags;
    endcase
    // Memory is read for direct and indexed sources, and for arithmetic into a destination.
    needs_read = (s_q.mode == opa_pkg::MODE_SRC_DIR) || (s_q.mode == opa_pkg::MODE_SRC_IDX) ||
                 (is_dst(s_q.mode) && (s_q.op != opa_pkg::ALU_MOV));
    alu.op    = s_q.op;
    alu.mode  = s_q.mode;
    alu.oper1 = s_q.op1;
    alu.x_val = s_q.idx;
    case (s_q.mode)
      opa_pkg::MODE_SRC_IMM: begin
        alu.a_in = tgt_val;
        alu.b_in = s_q.op1;
      end
      opa_pkg::MODE_SRC_DIR, opa_pkg::MODE_SRC_IDX: begin
        alu.a_in = tgt_val;
        alu.b_in = mem_rdata;
      end
      opa_pkg::MODE_DST_DIR, opa_pkg::MODE_DST_IDX: begin
        alu.a_in = mem_rdata;
        alu.b_in = tgt_val;
      end
      default: begin
        alu.a_in = mem_rdata;
        alu.b_in = s_q.op2;
      end
    endcase
    flags_new = s_q.flags;
    if (s_q.op == opa_pkg::ALU_ADD) begin
      flags_new[opa_pkg::FLAG_CARRY] = alu.carry;
    end
    flags_new[opa_pkg::FLAG_ZERO] = (alu.result == 8'h00);
    // The counter wraps at the top of the 16-bit space.
    pc_next = 16'({s_q.pc_high, s_q.pc_low} +
                  (is_long(s_q.mode) ? opa_pkg::LEN_LONG : opa_pkg::LEN_SHORT));
  end

  always_comb begin
    s_d       = s_q;
    s_d.mrd   = 1'b0;
    s_d.mwr   = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (bus_rd) begin
      case (bus_addr)
        opa_pkg::REG_INSTR:   s_d.rdata = {23'h000000, s_q.space, s_q.tgt, s_q.op, s_q.mode};
        opa_pkg::REG_OPER:    s_d.rdata = {16'h0000, s_q.op2, s_q.op1};
        opa_pkg::REG_ACC:     s_d.rdata = {24'h000000, s_q.acc};
        opa_pkg::REG_IDX:     s_d.rdata = {24'h000000, s_q.idx};
        opa_pkg::REG_SP:      s_d.rdata = {24'h000000, s_q.sp};
        opa_pkg::REG_FLAGS:   s_d.rdata = {24'h000000, s_q.flags};
        opa_pkg::REG_PC_LOW:  s_d.rdata = {24'h000000, s_q.pc_low};
        opa_pkg::REG_PC_HIGH: s_d.rdata = {24'h000000, s_q.pc_high};
        opa_pkg::REG_STATUS:  s_d.rdata = {31'h00000000, s_q.st != ST_IDLE};
        default:              s_d.rdata = 32'h0000_0000;
      endcase
    end
    case (s_q.st)
      ST_IDLE: begin
        // Operand and instruction writes are ignored while one is running.
        if (bus_wr && bus_addr == opa_pkg::REG_OPER) begin
          s_d.op1 = bus_wdata[opa_pkg::OPER_OP1_LSB +: 8];
          s_d.op2 = bus_wdata[opa_pkg::OPER_OP2_LSB +: 8];
        end
        if (bus_wr && bus_addr == opa_pkg::REG_INSTR) begin
          s_d.mode  = opa_pkg::opa_mode_e'(bus_wdata[opa_pkg::INSTR_MODE_LSB +: 3]);
          s_d.op    = opa_pkg::opa_alu_e'(bus_wdata[opa_pkg::INSTR_ALU_LSB +: 3]);
          s_d.tgt   = opa_pkg::opa_tgt_e'(bus_wdata[opa_pkg::INSTR_TGT_LSB +: 2]);
          s_d.space = bus_wdata[opa_pkg::INSTR_SPACE_BIT];
          // Only A or X can pair with memory; the MODE_DST_IDX destination uses A alone.
          if (s_d.mode != opa_pkg::MODE_SRC_IMM) begin
            s_d.tgt = (s_d.tgt == opa_pkg::TGT_X) ? opa_pkg::TGT_X : opa_pkg::TGT_A;
          end
          if (s_d.mode == opa_pkg::MODE_DST_IDX) begin
            s_d.tgt = opa_pkg::TGT_A;
          end
          if (s_d.mode > opa_pkg::MODE_DST_IDX_IMM) begin
            s_d.mode = opa_pkg::MODE_SRC_IMM;
          end
          if (s_d.op > opa_pkg::ALU_XOR) begin
            s_d.op = opa_pkg::ALU_MOV;
          end
          s_d.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        s_d.maddr  = alu.addr;
        s_d.mspace = s_q.space;
        s_d.mbank  = s_q.flags[opa_pkg::FLAG_BANK];
        if (needs_read) begin
          s_d.mrd = 1'b1;
          s_d.st  = ST_WAIT;
        end else begin
          s_d.st = ST_EXEC;
        end
      end
      ST_WAIT: s_d.st = ST_EXEC;
      ST_EXEC: begin
        if (is_dst(s_q.mode)) begin
          // The accumulator only feeds the store and is never written back.
          s_d.mwr    = 1'b1;
          s_d.mwdata = alu.result;
          s_d.maddr  = alu.addr;
          if (s_q.op != opa_pkg::ALU_MOV) begin
            s_d.flags = flags_new;
          end
        end else begin
          case (s_q.tgt)
            opa_pkg::TGT_A: s_d.acc = alu.result;
            opa_pkg::TGT_X: s_d.idx = alu.result;
            opa_pkg::TGT_SP: s_d.sp = alu.result;
            default: begin
              s_d.flags = (alu.result & opa_pkg::FLAGS_WR_MASK) |
                          (s_q.flags & ~opa_pkg::FLAGS_WR_MASK);
            end
          endcase
          if (s_q.op != opa_pkg::ALU_MOV && (s_q.tgt == opa_pkg::TGT_A ||
              s_q.tgt == opa_pkg::TGT_X)) begin
            s_d.flags = flags_new;
          end
        end
        s_d.pc_high = pc_next[15:8];
        s_d.pc_low  = pc_next[7:0];
        s_d.st      = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q         <= '0;
      s_q.st      <= ST_IDLE;
      s_q.acc     <= opa_pkg::ACC_RST;
      s_q.idx     <= opa_pkg::IDX_RST;
      s_q.sp      <= opa_pkg::SP_RST;
      s_q.flags   <= opa_pkg::FLAGS_RST;
      s_q.pc_high <= opa_pkg::PC_HIGH_RST;
      s_q.pc_low  <= opa_pkg::PC_LOW_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata     = s_q.rdata;
  assign mem_addr      = s_q.maddr;
  assign mem_reg_space = s_q.mspace;
  assign mem_bank      = s_q.mbank;
  assign mem_rd        = s_q.mrd;
  assign mem_wr        = s_q.mwr;
  assign mem_wdata     = s_q.mwdata;

  property p_pc_high;
    @(posedge clk) disable iff (sys_rst)
      (s_q.st != ST_EXEC) |=> (s_q.pc_high == $past(s_q.pc_high));
  endproperty
  a_pc_high: assert property (p_pc_high) else $error("pc high moved outside execute");

  property p_pc_low;
    @(posedge clk) disable iff (sys_rst)
      (s_q.st == ST_EXEC && !is_long(s_q.mode)) |=>
        ({s_q.pc_high, s_q.pc_low} == $past({s_q.pc_high, s_q.pc_low}) + opa_pkg::LEN_SHORT);
  endproperty
  a_pc_low: assert property (p_pc_low) else $error("pc did not step by two");

  property p_src_imm;
    @(posedge clk) disable iff (sys_rst)
      (s_q.st == ST_EXEC && s_q.mode == opa_pkg::MODE_SRC_IMM &&
       s_q.op == opa_pkg::ALU_MOV && s_q.tgt == opa_pkg::TGT_X) |=> (s_q.idx == $past(s_q.op1));
  endproperty
  a_src_imm: assert property (p_src_imm) else $error("immediate not loaded");

  property p_src_dir;
    @(posedge clk) disable iff (sys_rst)
      (s_q.st == ST_FETCH && s_q.mode == opa_pkg::MODE_SRC_DIR) |=>
        (mem_rd && mem_addr == $past(s_q.op1)) ##1 !mem_rd ##1 (s_q.st == ST_IDLE);
  endproperty
  a_src_dir: assert property (p_src_dir) else $error("direct source read wrong");

  property p_src_idx;
    @(posedge clk) disable iff (sys_rst)
      (s_q.st == ST_FETCH && s_q.mode == opa_pkg::MODE_SRC_IDX) |=>
        (mem_rd && mem_addr == 8'($past(s_q.op1) + $past(s_q.idx)));
  endproperty
  a_src_idx: assert property (p_src_idx) else $error("indexed source address wrong");

  property p_dst_dir;
    @(posedge clk) disable iff (sys_rst)
      (s_q.st == ST_EXEC && s_q.mode == opa_pkg::MODE_DST_DIR) |=>
        (mem_wr && mem_addr == $past(s_q.op1));
  endproperty
  a_dst_dir: assert property (p_dst_dir) else $error("direct destination write wrong");

  property p_dst_idx;
    @(posedge clk) disable iff (sys_rst)
      (s_q.st == ST_EXEC && s_q.mode == opa_pkg::MODE_DST_IDX && s_q.op == opa_pkg::ALU_MOV)
        |=> (mem_wr && mem_wdata == $past(s_q.acc));
  endproperty
  a_dst_idx: assert property (p_dst_idx) else $error("indexed store not from A");

  property p_dst_dir_imm;
    @(posedge clk) disable iff (sys_rst)
      (s_q.st == ST_EXEC && s_q.mode == opa_pkg::MODE_DST_DIR_IMM && s_q.op == opa_pkg::ALU_MOV)
        |=> (mem_wdata == $past(s_q.op2) &&
             {s_q.pc_high, s_q.pc_low} == $past({s_q.pc_high, s_q.pc_low}) + opa_pkg::LEN_LONG);
  endproperty
  a_dst_dir_imm: assert property (p_dst_dir_imm) else $error("literal store wrong");

  property p_dst_idx_imm;
    @(posedge clk) disable iff (sys_rst)
      (s_q.st == ST_FETCH && s_q.mode == opa_pkg::MODE_DST_IDX_IMM && s_q.op != opa_pkg::ALU_MOV)
        |=> mem_rd ##2 (mem_wr && mem_addr == $past(mem_addr, 2));
  endproperty
  a_dst_idx_imm: assert property (p_dst_idx_imm) else $error("indexed literal mismatch");

  property p_acc_kept;
    @(posedge clk) disable iff (sys_rst)
      (s_q.st == ST_EXEC && is_dst(s_q.mode)) |=> (s_q.acc == $past(s_q.acc));
  endproperty
  a_acc_kept: assert property (p_acc_kept) else $error("accumulator changed by store");

  property p_and_flags;
    @(posedge clk) disable iff (sys_rst)
      (s_q.st == ST_EXEC && s_q.mode == opa_pkg::MODE_SRC_IMM &&
       s_q.tgt == opa_pkg::TGT_F && s_q.op == opa_pkg::ALU_AND) |=>
        (s_q.flags == (($past(s_q.flags) & $past(s_q.op1) & opa_pkg::FLAGS_WR_MASK) |
                       ($past(s_q.flags) & ~opa_pkg::FLAGS_WR_MASK)));
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("flag AND wrong");

  property p_bank;
    @(posedge clk) disable iff (sys_rst)
      (mem_rd || mem_wr) |-> (mem_bank == s_q.flags[opa_pkg::FLAG_BANK]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select not from flags");

endmodule : opa_core

/* bench/cpu_operand_addressing_tb_top.sv */
`timescale 1ns/1ps
module cpu_operand_addressing_tb_top;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] bus_rdata;
  logic [7:0]  mem_addr;
  logic        mem_reg_space;
  logic        mem_bank;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic [7:0]  rd_addr;
  logic        rd_space;
  logic        rd_bank;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  int          num_errors;
  int          n_tests;
  int          cycles;
  logic [15:0] exp_pc;

  opa_core u_dut (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .bus_addr      (bus_addr),
    .bus_wdata     (bus_wdata),
    .bus_wr        (bus_wr),
    .bus_rd        (bus_rd),
    .bus_rdata     (bus_rdata),
    .mem_addr      (mem_addr),
    .mem_reg_space (mem_reg_space),
    .mem_bank      (mem_bank),
    .mem_rd        (mem_rd),
    .mem_wr        (mem_wr),
    .mem_wdata     (mem_wdata),
    .mem_rdata     (mem_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The memory answers with the address scrambled, and shows the inverse of its
  // last value outside the answer cycle so a late sample never matches by luck.
  always @(posedge clk) begin
    if (sys_rst) begin
      mem_rdata <= 8'h00;
      cycles    <= 0;
    end else begin
      mem_rdata <= (mem_rd === 1'b1) ? (mem_addr ^ 8'h5a) : ~mem_rdata;
      cycles    <= cycles + 1;
    end
    if (mem_rd === 1'b1) begin
      rd_addr  <= mem_addr;
      rd_space <= mem_reg_space;
      rd_bank  <= mem_bank;
    end
    if (mem_wr === 1'b1) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
    end
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask : rd

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(name, v, exp);
  endtask : rchk

  task automatic wait_idle();
    logic [31:0] v;
    for (int i = 0; i < 20; i++) begin
      rd(opa_pkg::REG_STATUS, v);
      if (v[0] === 1'b0) break;
      if (i == 19) chk("busy", v, 32'h0);
    end
  endtask : wait_idle

  task automatic exec(input logic [2:0] md, input logic [2:0] op, input logic [1:0] tg,
                      input logic sp, input logic [7:0] o1, input logic [7:0] o2);
    wr(opa_pkg::REG_OPER, {16'h0000, o2, o1});
    wr(opa_pkg::REG_INSTR, {23'h000000, sp, tg, op, md});
    // Mode 7 runs as an immediate source, so only modes 5 and 6 are three bytes long.
    exp_pc = exp_pc + ((md == 3'h5 || md == 3'h6) ? 16'h0003 : 16'h0002);
    wait_idle();
  endtask : exec

  task automatic chk_pc();
    rchk("pc_low", opa_pkg::REG_PC_LOW, {24'h0, exp_pc[7:0]});
    rchk("pc_high", opa_pkg::REG_PC_HIGH, {24'h0, exp_pc[15:8]});
  endtask : chk_pc

  task automatic t_reset();
    rchk("acc", opa_pkg::REG_ACC, 32'h0);
    rchk("flags", opa_pkg::REG_FLAGS, 32'h02);
    wr(opa_pkg::REG_PC_HIGH, 32'hff);
    chk_pc();
    rchk("unmapped", 8'h40, 32'h0);
  endtask : t_reset

  task automatic t_src_imm();
    exec(3'h0, 3'h0, 2'h1, 1'b0, 8'hf0, 8'h00);
    rchk("x", opa_pkg::REG_IDX, 32'hf0);
    exec(3'h0, 3'h0, 2'h2, 1'b0, 8'h3c, 8'h00);
    rchk("sp", opa_pkg::REG_SP, 32'h3c);
    exec(3'h0, 3'h3, 2'h3, 1'b0, 8'h17, 8'h00);
    exec(3'h0, 3'h2, 2'h3, 1'b0, 8'h09, 8'h00);
    rchk("flags", opa_pkg::REG_FLAGS, 32'h01);
    exec(3'h0, 3'h3, 2'h3, 1'b0, 8'h10, 8'h00);
    exec(3'h0, 3'h1, 2'h0, 1'b0, 8'h07, 8'h00);
    rchk("acc", opa_pkg::REG_ACC, 32'h07);
    chk_pc();
  endtask : t_src_imm

  task automatic t_src_mem();
    exec(3'h1, 3'h1, 2'h0, 1'b1, 8'h20, 8'h00);
    chk("rd_addr", rd_addr, 8'h20);
    chk("rd_space", rd_space, 1'b1);
    chk("rd_bank", rd_bank, 1'b1);
    rchk("acc", opa_pkg::REG_ACC, 32'h81);
    exec(3'h2, 3'h0, 2'h0, 1'b0, 8'h30, 8'h00);
    chk("rd_addr", rd_addr, 8'h20);
    chk("rd_space", rd_space, 1'b0);
    rchk("acc", opa_pkg::REG_ACC, 32'h7a);
    exec(3'h0, 3'h2, 2'h3, 1'b0, 8'h01, 8'h00);
    exec(3'h1, 3'h0, 2'h1, 1'b1, 8'h05, 8'h00);
    chk("rd_bank", rd_bank, 1'b0);
    rchk("x", opa_pkg::REG_IDX, 32'h5f);
    chk_pc();
  endtask : t_src_mem

  task automatic t_dst();
    exec(3'h3, 3'h1, 2'h0, 1'b0, 8'h33, 8'h00);
    chk("rd_addr", rd_addr, 8'h33);
    chk("wr_addr", wr_addr, 8'h33);
    chk("wr_data", wr_data, 8'he3);
    exec(3'h4, 3'h1, 2'h0, 1'b0, 8'hb0, 8'h00);
    chk("rd_addr", rd_addr, 8'h0f);
    chk("wr_addr", wr_addr, 8'h0f);
    chk("wr_data", wr_data, 8'hcf);
    rchk("acc", opa_pkg::REG_ACC, 32'h7a);
    chk_pc();
  endtask : t_dst

  task automatic t_dst_imm();
    exec(3'h5, 3'h0, 2'h0, 1'b0, 8'h44, 8'h99);
    chk("wr_addr", wr_addr, 8'h44);
    chk("wr_data", wr_data, 8'h99);
    exec(3'h5, 3'h1, 2'h0, 1'b0, 8'h45, 8'h01);
    chk("wr_data", wr_data, 8'h20);
    exec(3'h6, 3'h1, 2'h0, 1'b0, 8'ha2, 8'h02);
    chk("rd_addr", rd_addr, 8'h01);
    chk("wr_addr", wr_addr, 8'h01);
    chk("wr_data", wr_data, 8'h5d);
    rchk("acc", opa_pkg::REG_ACC, 32'h7a);
    chk_pc();
  endtask : t_dst_imm

  task automatic t_extra();
    exec(3'h0, 3'h4, 2'h0, 1'b0, 8'h7a, 8'h00);
    rchk("acc", opa_pkg::REG_ACC, 32'h00);
    rchk("flags", opa_pkg::REG_FLAGS, 32'h03);
    exec(3'h0, 3'h1, 2'h0, 1'b0, 8'hff, 8'h00);
    exec(3'h0, 3'h1, 2'h0, 1'b0, 8'h01, 8'h00);
    rchk("flags", opa_pkg::REG_FLAGS, 32'h07);
    exec(3'h4, 3'h0, 2'h1, 1'b0, 8'h10, 8'h00);
    chk("wr_addr", wr_addr, 8'h6f);
    chk("wr_data", wr_data, 8'h00);
    // The second operand write lands while the first instruction runs and must be dropped.
    wr(opa_pkg::REG_OPER, 32'h0000_0055);
    wr(opa_pkg::REG_INSTR, 32'h0000_0000);
    wr(opa_pkg::REG_OPER, 32'h0000_0066);
    exp_pc = exp_pc + 16'h0002;
    wait_idle();
    rchk("acc", opa_pkg::REG_ACC, 32'h55);
    rchk("oper", opa_pkg::REG_OPER, 32'h55);
    exec(3'h7, 3'h7, 2'h1, 1'b0, 8'h42, 8'h00);
    rchk("x", opa_pkg::REG_IDX, 32'h42);
    rchk("instr", opa_pkg::REG_INSTR, 32'h040);
    chk_pc();
  endtask : t_extra

  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  initial begin
    sys_rst    = 1'b1;
    bus_addr   = 8'h00;
    bus_wdata  = 32'h0;
    bus_wr     = 1'b0;
    bus_rd     = 1'b0;
    num_errors = 0;
    n_tests    = 0;
    exp_pc     = 16'h0000;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_src_imm();
    t_src_mem();
    t_dst();
    t_dst_imm();
    t_extra();
    test_done();
  end
endmodule : cpu_operand_addressing_tb_top
